//--- common/otp_read_pkg.sv
// constants for the security-area read path of a serial memory slave
// assumes the serial clock and data are sampled as synchronous inputs on clk_in
package otp_read_pkg;
	localparam int PTR_W = 16;
	localparam int SEL_BITS = 7;
	localparam int DEPTH = 128;
	localparam int HALF_W = 6;
	localparam int SEL_W = 3;
	localparam logic [3:0] CODE_SECURITY = 4'hB;
	localparam logic [3:0] CODE_MAIN = 4'hA;
	localparam int CODE_MSB = 7;
	localparam int CODE_LSB = 4;
	localparam int SEL_MSB = 3;
	localparam int SEL_LSB = 1;
	localparam int DIR_BIT = 0;
	localparam logic [3:0] BITS_PER_BYTE = 4'h8;
	localparam logic [3:0] LAST_TX_BIT = 4'h7;
	localparam logic [PTR_W-1:0] PTR_RESET = 16'h0000;
	localparam logic [PTR_W-1:0] PTR_STEP = 16'h0001;
	localparam logic USER_HALF = 1'b0;
	localparam logic FACTORY_HALF = 1'b1;

	typedef enum logic [2:0] {
		ST_IDLE,
		ST_CTRL,
		ST_ADDR_HI,
		ST_ADDR_LO,
		ST_ACK,
		ST_TX,
		ST_TX_ACK
	} slave_state_t;
endpackage : otp_read_pkg

//--- hw/byte_buffer2.sv
// two-entry buffer with valid and ready on both sides
// assumes one clock, synchronous active-high reset and a freezing clock enable
`timescale 1ns/1ps
module byte_buffer2 #(
	parameter int WIDTH = 8
) (
	input wire logic clk_in,
	input wire logic sys_rst_in,
	input wire logic ce_in,
	input wire logic flush_in,
	input wire logic in_valid_in,
	output logic in_ready_out,
	input wire logic [WIDTH-1:0] in_data_in,
	output logic out_valid_out,
	input wire logic out_ready_in,
	output logic [WIDTH-1:0] out_data_out
);
	logic [WIDTH-1:0] slot_ff [2];
	logic [WIDTH-1:0] nxt_slot [2];
	logic wr_sel_ff, nxt_wr_sel;
	logic rd_sel_ff, nxt_rd_sel;
	logic [1:0] count_ff, nxt_count;
	logic push, pop;

	// full and empty come straight from the occupancy count
	assign in_ready_out = (count_ff != 2'h2);
	assign out_valid_out = (count_ff != 2'h0);
	assign out_data_out = slot_ff[rd_sel_ff];
	assign push = in_valid_in & in_ready_out;
	assign pop = out_ready_in & out_valid_out;

	// next occupancy; flush drops anything still waiting
	always_comb begin
		nxt_slot = slot_ff;
		nxt_wr_sel = wr_sel_ff;
		nxt_rd_sel = rd_sel_ff;
		nxt_count = count_ff;
		if (flush_in) begin
			nxt_wr_sel = 1'b0;
			nxt_rd_sel = 1'b0;
			nxt_count = 2'h0;
		end else begin
			if (push) begin
				nxt_slot[wr_sel_ff] = in_data_in;
				nxt_wr_sel = ~wr_sel_ff;
			end
			if (pop) begin
				nxt_rd_sel = ~rd_sel_ff;
			end
			nxt_count = count_ff + {1'b0, push} - {1'b0, pop};
		end
	end

	always_ff @(posedge clk_in) begin
		if (sys_rst_in) begin
			slot_ff[0] <= '0;
			slot_ff[1] <= '0;
			wr_sel_ff <= 1'b0;
			rd_sel_ff <= 1'b0;
			count_ff <= 2'h0;
		end else if (ce_in) begin
			slot_ff <= nxt_slot;
			wr_sel_ff <= nxt_wr_sel;
			rd_sel_ff <= nxt_rd_sel;
			count_ff <= nxt_count;
		end
	end
endmodule : byte_buffer2

//--- hw/otp_security_read.sv
// serial-bus slave that serves reads of the 128-byte one-time-programmable area
// assumes scl_in and sda_in are already synchronous to clk_in and much slower than it;
// sda is open drain: the pad pulls low while sda_oe_out is high
`timescale 1ns/1ps
module otp_security_read (
	input wire logic clk_in,
	input wire logic sys_rst_in,
	input wire logic ce_in,
	input wire logic scl_in,
	input wire logic sda_in,
	output logic sda_out,
	output logic sda_oe_out,
	input wire logic [otp_read_pkg::SEL_W-1:0] chip_sel_in,
	input wire logic write_busy_in,
	input wire logic user_we_in,
	input wire logic factory_we_in,
	input wire logic [otp_read_pkg::HALF_W-1:0] otp_waddr_in,
	input wire logic [7:0] otp_wdata_in,
	output logic [otp_read_pkg::PTR_W-1:0] ptr_out,
	output logic read_active_out
);
	import otp_read_pkg::*;

	logic [7:0] otp_mem [DEPTH];
	slave_state_t state_ff, nxt_state;
	slave_state_t after_ff, nxt_after;
	logic [3:0] cnt_ff, nxt_cnt;
	logic [7:0] shreg_ff, nxt_shreg;
	logic [7:0] tx_ff, nxt_tx;
	logic [7:0] addr_hi_ff, nxt_addr_hi;
	logic [PTR_W-1:0] ptr_ff, nxt_ptr;
	logic oe_ff, nxt_oe;
	logic push_req_ff, nxt_push_req;
	logic rd_active_ff, nxt_rd_active;
	logic acked_ff, nxt_acked;
	logic scl_q_ff, sda_q_ff;
	logic scl_rise, scl_fall, start_det, stop_det;
	logic ctrl_sel, ctrl_busy_free, ctrl_read, ctrl_sec, ctrl_main;
	logic buf_in_ready, buf_out_valid, pop, flush;
	logic [7:0] buf_data, fetch_byte;

	assign sda_out = 1'b0; // open drain: only ever pulls low
	assign sda_oe_out = oe_ff;
	assign ptr_out = ptr_ff; // main-array logic shares this pointer
	assign read_active_out = rd_active_ff;

	// bus events from the previous sample; we only move sda while scl is low
	assign scl_rise = ~scl_q_ff & scl_in;
	assign scl_fall = scl_q_ff & ~scl_in;
	assign start_det = scl_q_ff & scl_in & sda_q_ff & ~sda_in;
	assign stop_det = scl_q_ff & scl_in & ~sda_q_ff & sda_in;

	// control byte decode
	assign ctrl_sec = (shreg_ff[CODE_MSB:CODE_LSB] == CODE_SECURITY);
	assign ctrl_main = (shreg_ff[CODE_MSB:CODE_LSB] == CODE_MAIN);
	assign ctrl_sel = (shreg_ff[SEL_MSB:SEL_LSB] == chip_sel_in);
	assign ctrl_read = shreg_ff[DIR_BIT];
	assign ctrl_busy_free = ~write_busy_in;

	// byte select drops the upper pointer bits, so the location wraps at 128
	assign fetch_byte = otp_mem[ptr_ff[SEL_BITS-1:0]];

	// user half sits at 0-63, factory half at 64-127
	always_ff @(posedge clk_in) begin
		if (ce_in && user_we_in) begin
			otp_mem[{USER_HALF, otp_waddr_in}] <= otp_wdata_in;
		end
		if (ce_in && factory_we_in) begin
			otp_mem[{FACTORY_HALF, otp_waddr_in}] <= otp_wdata_in;
		end
	end

	// the buffer decouples the fetch from the shifter, so a slow bus never loses a byte
	byte_buffer2 #(
		.WIDTH(8)
	) u_tx_buf (
		.clk_in(clk_in),
		.sys_rst_in(sys_rst_in),
		.ce_in(ce_in),
		.flush_in(flush),
		.in_valid_in(push_req_ff),
		.in_ready_out(buf_in_ready),
		.in_data_in(fetch_byte),
		.out_valid_out(buf_out_valid),
		.out_ready_in(pop),
		.out_data_out(buf_data)
	);

	// protocol engine: next-state for all bus-facing state
	always_comb begin
		nxt_state = state_ff;
		nxt_after = after_ff;
		nxt_cnt = cnt_ff;
		nxt_shreg = shreg_ff;
		nxt_tx = tx_ff;
		nxt_addr_hi = addr_hi_ff;
		nxt_ptr = ptr_ff;
		nxt_oe = oe_ff;
		nxt_rd_active = rd_active_ff;
		nxt_acked = acked_ff;
		pop = 1'b0;
		flush = 1'b0;
		// a pending fetch waits for buffer space instead of being dropped
		nxt_push_req = push_req_ff & ~buf_in_ready;
		if (start_det) begin
			// a repeated start ends a write but keeps the loaded pointer
			nxt_state = ST_CTRL;
			nxt_cnt = 4'h0;
			nxt_oe = 1'b0;
			nxt_rd_active = 1'b0;
			nxt_acked = 1'b0;
			nxt_push_req = 1'b0;
			flush = 1'b1;
		end else if (stop_det) begin
			nxt_state = ST_IDLE;
			nxt_oe = 1'b0;
			nxt_acked = 1'b0;
			nxt_push_req = 1'b0;
			flush = 1'b1;
			if (rd_active_ff) begin
				nxt_ptr = ptr_ff + PTR_STEP;
			end
			nxt_rd_active = 1'b0;
		end else begin
			case (state_ff)
				ST_CTRL, ST_ADDR_HI, ST_ADDR_LO: begin
					if (scl_rise && cnt_ff != BITS_PER_BYTE) begin
						nxt_shreg = {shreg_ff[6:0], sda_in};
						nxt_cnt = cnt_ff + 4'h1;
					end else if (scl_fall && cnt_ff == BITS_PER_BYTE) begin
						nxt_cnt = 4'h0;
						nxt_state = ST_ACK;
						nxt_oe = 1'b1;
						if (state_ff == ST_CTRL) begin
							if (!(ctrl_sel && ctrl_busy_free)) begin
								nxt_state = ST_IDLE;
								nxt_oe = 1'b0;
							end else if (ctrl_read && ctrl_sec) begin
								nxt_after = ST_TX;
								nxt_push_req = 1'b1;
								nxt_rd_active = 1'b1;
							end else if (!ctrl_read && (ctrl_sec || ctrl_main)) begin
								nxt_after = ST_ADDR_HI;
							end else begin
								nxt_state = ST_IDLE; // main-array reads are served elsewhere
								nxt_oe = 1'b0;
							end
						end else if (state_ff == ST_ADDR_HI) begin
							nxt_addr_hi = shreg_ff;
							nxt_after = ST_ADDR_LO;
						end else begin
							nxt_ptr = {addr_hi_ff, shreg_ff};
							nxt_after = ST_IDLE;
						end
					end
				end
				ST_ACK: begin
					if (scl_fall) begin
						nxt_state = after_ff;
						nxt_oe = 1'b0;
						if (after_ff == ST_TX) begin
							pop = buf_out_valid;
							nxt_tx = buf_data;
							nxt_oe = ~buf_data[7]; // msb first
						end
					end
				end
				ST_TX: begin
					if (scl_fall) begin
						if (cnt_ff == LAST_TX_BIT) begin
							nxt_oe = 1'b0; // release for the master's acknowledge
							nxt_state = ST_TX_ACK;
						end else begin
							nxt_tx = {tx_ff[6:0], 1'b1};
							nxt_oe = ~tx_ff[6];
							nxt_cnt = cnt_ff + 4'h1;
						end
					end
				end
				ST_TX_ACK: begin
					if (scl_rise) begin
						if (!sda_in) begin
							nxt_ptr = ptr_ff + PTR_STEP;
							nxt_push_req = 1'b1;
							nxt_acked = 1'b1;
						end else begin
							nxt_state = ST_IDLE; // nack: wait for stop
						end
					end else if (scl_fall && acked_ff) begin
						nxt_acked = 1'b0;
						pop = buf_out_valid;
						nxt_tx = buf_data;
						nxt_oe = ~buf_data[7];
						nxt_cnt = 4'h0;
						nxt_state = ST_TX;
					end
				end
				ST_IDLE: begin
					nxt_oe = 1'b0;
				end
				default: begin
					nxt_state = ST_IDLE;
					nxt_oe = 1'b0;
				end
			endcase
		end
	end

	// pointer resets to zero; the pin samples idle high
	always_ff @(posedge clk_in) begin
		if (sys_rst_in) begin
			state_ff <= ST_IDLE;
			after_ff <= ST_IDLE;
			cnt_ff <= 4'h0;
			shreg_ff <= 8'h00;
			tx_ff <= 8'hFF;
			addr_hi_ff <= 8'h00;
			ptr_ff <= PTR_RESET;
			oe_ff <= 1'b0;
			push_req_ff <= 1'b0;
			rd_active_ff <= 1'b0;
			acked_ff <= 1'b0;
			scl_q_ff <= 1'b1;
			sda_q_ff <= 1'b1;
		end else if (ce_in) begin
			state_ff <= nxt_state;
			after_ff <= nxt_after;
			cnt_ff <= nxt_cnt;
			shreg_ff <= nxt_shreg;
			tx_ff <= nxt_tx;
			addr_hi_ff <= nxt_addr_hi;
			ptr_ff <= nxt_ptr;
			oe_ff <= nxt_oe;
			push_req_ff <= nxt_push_req;
			rd_active_ff <= nxt_rd_active;
			acked_ff <= nxt_acked;
			scl_q_ff <= scl_in;
			sda_q_ff <= sda_in;
		end
	end
endmodule : otp_security_read

//--- bench/otp_security_read_chk.sv
// port-level assertions for the security-area read slave
// assumes one clock domain and a bench that never raises busy in mid-read
`timescale 1ns/1ps
module otp_security_read_chk (
	input wire logic clk_in,
	input wire logic sys_rst_in,
	input wire logic ce_in,
	input wire logic scl_in,
	input wire logic sda_in,
	input wire logic sda_out,
	input wire logic sda_oe_out,
	input wire logic write_busy_in,
	input wire logic [otp_read_pkg::PTR_W-1:0] ptr_out,
	input wire logic read_active_out
);
	import otp_read_pkg::*;
	default clocking cb @(posedge clk_in);
	endclocking
	default disable iff (sys_rst_in);
	// bus conditions seen at the inputs
	wire logic stop_seen;
	wire logic start_seen;
	assign stop_seen = scl_in && sda_in && !sda_oe_out;
	assign start_seen = scl_in && !sda_in && !sda_oe_out;
	AST_SDA_VALUE: assert property (sda_out == 1'b0)
		else $error("data value not zero");
	AST_RESET: assert property (disable iff (1'b0) sys_rst_in && ce_in |=>
		ptr_out == 16'h0000 && !sda_oe_out && !read_active_out)
		else $error("reset state wrong");
	// a drive change while scl is high would fake a start or stop
	AST_OE_EDGE: assert property ($changed(sda_oe_out) |-> !$past(scl_in))
		else $error("drive changed with scl high");
	AST_BUSY: assert property ($rose(read_active_out) |->
		!write_busy_in && !$past(write_busy_in))
		else $error("read accepted while busy");
	AST_PTR_STEP: assert property ($changed(ptr_out) && $past(read_active_out) |->
		ptr_out == $past(ptr_out) + 16'h0001)
		else $error("pointer step during read not one");
	AST_READ_ACK: assert property ($rose(read_active_out) |-> ##[0:3] sda_oe_out)
		else $error("read control byte not acknowledged");
	AST_STOP: assert property (stop_seen && $past(scl_in) && !$past(sda_in) |->
		##[0:3] !read_active_out && !sda_oe_out)
		else $error("stop did not end read");
	AST_START: assert property (start_seen && $past(scl_in) && $past(sda_in) |->
		##[0:3] !read_active_out)
		else $error("start did not end read");
	// a low clock enable must freeze the shared pointer and the bus drive
	AST_CE_HOLD: assert property (!ce_in |=> $stable(ptr_out) && $stable(sda_oe_out) && $stable(read_active_out))
		else $error("state moved with clock enable low");
	COV_MASTER_ACK: cover property (read_active_out && $rose(scl_in) && !sda_in);
	COV_STOP_READ: cover property (read_active_out ##1 !read_active_out);
	COV_BUSY: cover property (write_busy_in && $rose(scl_in));
endmodule : otp_security_read_chk

bind otp_security_read otp_security_read_chk u_chk (.clk_in(clk_in), .sys_rst_in(sys_rst_in),
	.ce_in(ce_in), .scl_in(scl_in), .sda_in(sda_in), .sda_out(sda_out),
	.sda_oe_out(sda_oe_out), .write_busy_in(write_busy_in), .ptr_out(ptr_out),
	.read_active_out(read_active_out));

//--- bench/i2c_master_model.sv
// behavioural serial bus master: start, stop and nine-bit byte slots
// assumes a pull-up on the data wire resolved by the bench
`timescale 1ns/1ps
module i2c_master_model (
	input wire logic clk_in,
	input wire logic sda_in,
	output logic scl_out,
	output logic sda_low_out
);
	initial begin
		scl_out = 1'b1;
		sda_low_out = 1'b0;
	end
	// changes land one ns after an edge, so the slave never races them
	task tick(input int n);
		repeat (n) @(posedge clk_in);
		#1;
	endtask : tick
	// start also serves as repeated start; sda falls while scl high
	task start();
		tick(3); scl_out = 1'b0;
		tick(2); sda_low_out = 1'b0;
		tick(3); scl_out = 1'b1;
		tick(3); sda_low_out = 1'b1;
	endtask : start
	task stop();
		tick(3); scl_out = 1'b0;
		tick(2); sda_low_out = 1'b1;
		tick(3); scl_out = 1'b1;
		tick(3); sda_low_out = 1'b0;
		tick(3);
	endtask : stop
	// eight bits msb first then the ack slot; mrel high leaves the ack slot released
	task xfer(input logic [7:0] d, input logic mrel, output logic [7:0] q, output logic ack);
		for (int i = 8; i >= 0; i--) begin
			tick(3); scl_out = 1'b0;
			tick(2); sda_low_out = (i == 0) ? !mrel : !d[i-1];
			tick(2); scl_out = 1'b1;
			tick(2);
			if (i == 0) ack = !sda_in;
			else q[i-1] = sda_in;
		end
	endtask : xfer
endmodule : i2c_master_model

//--- bench/otp_security_read_tb_top.sv
// self-checking bench: preloads the area, then reads it through the serial master
// assumes the design answers within the bit slots of a slow scl
`timescale 1ns/1ps
module otp_security_read_tb_top;
	import otp_read_pkg::*;
	logic clk = 1'b0, rst = 1'b1, busy = 1'b0, uwe = 1'b0, fwe = 1'b0, q_ack, ce = 1'b1;
	logic [SEL_W-1:0] sel = 3'h5;
	logic [5:0] wa = 6'h00;
	logic [7:0] wd = 8'h00, q, ctl;
	logic [PTR_W-1:0] ptr, a;
	logic scl, mlow, dsda, oe, ract;
	wire logic sda = (oe ? dsda : 1'b1) & !mlow;
	int seed = 32'h3c46, err_total = 0, num_checks = 0, eptr;
	logic [7:0] mem [DEPTH];
	always #2.5 clk = !clk;
	otp_security_read u_dut (.clk_in(clk), .sys_rst_in(rst), .ce_in(ce), .scl_in(scl),
		.sda_in(sda), .sda_out(dsda), .sda_oe_out(oe), .chip_sel_in(sel),
		.write_busy_in(busy), .user_we_in(uwe), .factory_we_in(fwe), .otp_waddr_in(wa),
		.otp_wdata_in(wd), .ptr_out(ptr), .read_active_out(ract));
	i2c_master_model u_m (.clk_in(clk), .sda_in(sda), .scl_out(scl), .sda_low_out(mlow));
	task check(input string nm, input logic [15:0] seen, input logic [15:0] exp);
		num_checks++;
		if (seen !== exp) begin
			err_total++;
			$display("ERROR %s expected %h seen %h", nm, exp, seen);
		end
	endtask : check
	task stop_test();
		$display("checks %0d mismatches %0d", num_checks, err_total);
		if (err_total == 0 && num_checks > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask : stop_test
	// write control plus two address bytes; no stop, so a read may follow
	task set_addr(input logic [3:0] code, input logic [15:0] ad);
		u_m.start();
		u_m.xfer({code, sel, 1'b0}, 1'b1, q, q_ack);
		u_m.xfer(ad[15:8], 1'b1, q, q_ack);
		u_m.xfer(ad[7:0], 1'b1, q, q_ack);
		check("addr ack", q_ack, 1'b1);
		eptr = ad;
	endtask : set_addr
	// read n bytes, acking all but the last, then stop
	task rd(input int n);
		u_m.start();
		u_m.xfer({CODE_SECURITY, sel, 1'b1}, 1'b1, q, q_ack);
		check("read ack", q_ack, 1'b1);
		for (int i = 0; i < n; i++) begin
			u_m.xfer(8'hFF, i == n - 1, q, q_ack);
			check("data", q, mem[eptr % DEPTH]);
			check("active", ract, 1'b1);
			eptr = (eptr + 1) % 65536;
		end
		u_m.stop();
		check("active off", ract, 1'b0);
		check("ptr", ptr, eptr[15:0]);
	endtask : rd
	initial begin
		#200000;
		err_total++;
		stop_test();
	end
	initial begin
		repeat (8) @(posedge clk);
		#1 rst = 1'b0;
		// preload both halves with random bytes
		for (int i = 0; i < DEPTH; i++) begin
			wd = 8'($random(seed));
			wa = i[5:0];
			uwe = !i[6];
			fwe = i[6];
			mem[i] = wd;
			@(posedge clk);
			#1;
		end
		uwe = 1'b0;
		fwe = 1'b0;
		// a write strobe with the clock enable low must not land; location 5 is read later
		ce = 1'b0;
		uwe = 1'b1;
		wa = 6'h05;
		wd = ~mem[5];
		repeat (2) @(posedge clk);
		#1;
		uwe = 1'b0;
		ce = 1'b1;
		a = 16'($random(seed));
		set_addr(CODE_SECURITY, {a[15:7], 7'h7E});
		rd(3);
		rd(1);
		a = 16'($random(seed));
		set_addr(CODE_MAIN, a);
		u_m.stop();
		rd(1);
		set_addr(CODE_SECURITY, 16'h0040);
		rd(130);
		// refused control bytes: busy, wrong select, main-array read, unknown code
		for (int k = 0; k < 4; k++) begin
			busy = (k == 0);
			ctl = (k == 3) ? {4'h6, sel, 1'b0} :
				{(k == 2) ? CODE_MAIN : CODE_SECURITY, (k == 1) ? ~sel : sel, 1'b1};
			u_m.start();
			u_m.xfer(ctl, 1'b1, q, q_ack);
			check("refused", q_ack, 1'b0);
			u_m.stop();
			busy = 1'b0;
			check("ptr kept", ptr, eptr[15:0]);
		end
		@(posedge clk);
		#1 rst = 1'b1;
		repeat (8) @(posedge clk);
		#1 rst = 1'b0;
		check("ptr reset", ptr, PTR_RESET);
		eptr = 0;
		rd(1);
		stop_test();
	end
endmodule : otp_security_read_tb_top
